//--- logic/lcdsm_pkg.sv
// constants, field layout and carrier types of the lcd scan and power block
`default_nettype none
package lcdsm_pkg;
  // clock rate and derived timing
  localparam int CLK_HZ = 40000000;
  localparam int POR_TIME_MS = 15; // supply settle wait before reset
  localparam int POR_CYCLES = (CLK_HZ / 1000) * POR_TIME_MS;
  localparam int POR_CNT_W = 20;
  localparam int FRAME_RATE_HZ = 90; // nominal field rate
  localparam int LINE_CYCLES = CLK_HZ / (FRAME_RATE_HZ * 128);
  localparam int LINE_CNT_W = 12;
  localparam logic [3:0] RESET_SEQ_CYCLES = 4'hF; // length of reset pass
  // display ram geometry
  localparam logic [7:0] COL_LAST = 8'hEF; // column 239
  localparam logic [4:0] PAGE_LAST = 5'h13; // page 19
  localparam int RAM_DEPTH = 4800; // 20 pages of 240 bytes
  localparam int RAM_AW = 13;
  localparam logic [6:0] MUX_LAST_96 = 7'h5F; // last com at mux 96
  localparam logic [6:0] MUX_LAST_128 = 7'h7F; // last com at mux 128
  // operating mode codes
  localparam logic [1:0] OM_RESET = 2'b00;
  localparam logic [1:0] OM_SLEEP = 2'b10;
  localparam logic [1:0] OM_NORMAL = 2'b11;
  // register offsets
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CMD = 4'h0; // status read, command write
  localparam logic [3:0] REG_DATA = 4'h1; // display data port
  localparam logic [3:0] REG_ADDR_CTRL = 4'h2;
  localparam logic [3:0] REG_MAPPING = 4'h3;
  localparam logic [3:0] REG_DISP_CTRL = 4'h4;
  localparam logic [3:0] REG_MUX = 4'h5;
  localparam logic [3:0] REG_START_LINE = 4'h6;
  localparam logic [3:0] REG_COLUMN = 4'h7;
  localparam logic [3:0] REG_PAGE = 4'h8;
  localparam logic [3:0] REG_POWER = 4'h9;
  // field positions
  localparam int BIT_WRAP = 0;
  localparam int BIT_PAGE_DIR = 2;
  localparam int BIT_COL_MIRROR = 2;
  localparam int BIT_ROW_MIRROR = 3;
  localparam int BIT_DRIVER_EN = 2;
  localparam int BIT_MUX128 = 0;
  localparam int BIT_EXT_SUPPLY = 0;
  localparam logic [7:0] SYS_RESET_CMD = 8'hE2; // software reset code
  // control register set
  typedef struct packed {
    logic wrapEnable;
    logic pageDir; // 0 steps up, 1 steps down
    logic colMirror;
    logic rowMirror;
    logic driverEnable;
    logic mux128; // 1 selects 128 lines, 0 selects 96
    logic extSupply; // drive voltage supplied from outside
    logic [6:0] startLine;
  } lcdsm_ctrl_t;
  localparam lcdsm_ctrl_t CTRL_DEFAULT = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
    1'b1, 1'b0, 7'h00};
  // scan position handed out by the line generator
  typedef struct packed {
    logic firstLine;
    logic [6:0] comIndex;
    logic [6:0] ramLine;
  } lcdsm_scan_t;
endpackage
`default_nettype wire

//--- logic/lcdsm_ram.sv
// display data memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module lcdsm_ram (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic writeEn,
  input wire logic readEn,
  input wire logic [lcdsm_pkg::RAM_AW-1:0] addr,
  input wire logic [7:0] writeData,
  output logic [7:0] readData
);
  // storage array, contents survive every reset
  logic [7:0] mem [lcdsm_pkg::RAM_DEPTH];
  logic [7:0] next_readData;

  // read data updates only on a read
  always_comb begin
    next_readData = readData;
    if (readEn) begin
      next_readData = mem[addr];
    end
  end

  // array write, no reset on purpose
  always_ff @(posedge clk) begin
    if (ce && writeEn) begin
      mem[addr] <= writeData;
    end
  end

  // read data register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readData <= 8'h00;
    end else if (ce) begin
      readData <= next_readData;
    end
  end
endmodule
`default_nettype wire

//--- logic/lcdsm_line_gen.sv
// field scan: com counter and ram line address
`timescale 1ns/10ps
`default_nettype none
module lcdsm_line_gen #(
  parameter int LINE_CYCLES = lcdsm_pkg::LINE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic run,
  input wire lcdsm_pkg::lcdsm_ctrl_t ctrl,
  output lcdsm_pkg::lcdsm_scan_t scan
);
  logic [lcdsm_pkg::LINE_CNT_W-1:0] lineTimer; // cycles within a line
  logic [lcdsm_pkg::LINE_CNT_W-1:0] next_lineTimer;
  lcdsm_pkg::lcdsm_scan_t next_scan;
  logic [6:0] muxLast; // last com of the field
  logic [6:0] firstAddr; // ram line of the first com

  // next scan position
  always_comb begin
    muxLast = ctrl.mux128 ? lcdsm_pkg::MUX_LAST_128
      : lcdsm_pkg::MUX_LAST_96;
    firstAddr = ctrl.rowMirror ? 7'(ctrl.startLine + muxLast)
      : ctrl.startLine;
    next_lineTimer = lineTimer;
    next_scan = scan;
    if (!run) begin
      // idle: park on the first line of a field
      next_lineTimer = '0;
      next_scan = '{1'b1, 7'h00, firstAddr};
    end else if (lineTimer ==
        lcdsm_pkg::LINE_CNT_W'(LINE_CYCLES - 1)) begin
      next_lineTimer = '0;
      if (scan.comIndex >= muxLast) begin
        // field end: restart at com 0 regardless of mapping
        next_scan = '{1'b1, 7'h00, firstAddr};
      end else begin
        next_scan.firstLine = 1'b0;
        next_scan.comIndex = 7'(scan.comIndex + 7'h01);
        // seven bits wrap modulo 128 on their own
        next_scan.ramLine = ctrl.rowMirror ? 7'(scan.ramLine - 7'h01)
          : 7'(scan.ramLine + 7'h01);
      end
    end else begin
      next_lineTimer = lcdsm_pkg::LINE_CNT_W'(lineTimer + 1'b1);
    end
  end

  // scan registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lineTimer <= '0;
      scan <= '{1'b1, 7'h00, 7'h00};
    end else if (ce) begin
      lineTimer <= next_lineTimer;
      scan <= next_scan;
    end
  end
endmodule
`default_nettype wire

//--- logic/lcdsm_top.sv
// lcd controller core: ram addressing, scan, reset and power modes
//
// Summary of operation
// - wrap on: page end clears column, steps page
// - page wraps between 0 and 19
// - column mirror uses 239 minus column
// - coms scan first to last, fixed order
// - normal rows: start line, then plus one
// - mirrored rows: start plus mux minus one, decrement
// - power-on waits 15 ms then resets
// - reset command or reset pin starts reset
// - reset holds status bits, ignores other commands
// - reset restores control register defaults
// - mode codes 00 10 11 gate blocks
// - driver enable write selects sleep or normal
// - drain only in reset, sleep keeps charge
// - drivers wait for power ready
// - external drive supply not drained until a reset clears extSupply
// - offset 0 selects command, offset 1 display data
// - wrap off: column stops at 239
// - driver enable clear idles drivers, sleeps
`timescale 1ns/10ps
`default_nettype none
module lcdsm_top #(
  parameter int POR_CYCLES = lcdsm_pkg::POR_CYCLES,
  parameter int LINE_CYCLES = lcdsm_pkg::LINE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [lcdsm_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wstrobe,
  input wire logic rstrobe,
  output logic [7:0] rdata,
  input wire logic rstPinN,
  input wire logic powerGood,
  output logic [1:0] operatingMode,
  output logic scanClockEnable,
  output logic pumpEnable,
  output logic drainEnable,
  output logic comDriveEnable,
  output logic segDriveEnable,
  output lcdsm_pkg::lcdsm_scan_t scan
);
  // reset sequencer states
  typedef enum logic [1:0] {
    PorWait,
    ResetSeq,
    Running
  } lcdsm_state_t;

  lcdsm_state_t state, next_state;
  logic [lcdsm_pkg::POR_CNT_W-1:0] porCount; // power-on settle timer
  logic [lcdsm_pkg::POR_CNT_W-1:0] next_porCount;
  logic [3:0] seqCount; // reset pass timer
  logic [3:0] next_seqCount;
  logic pinSync1; // first stage, read only by pinSync2
  logic pinSync2; // synchronised reset pin, low active
  logic pwrSync1; // first stage, read only by pwrSync2
  logic pwrSync2; // synchronised power-ready level
  lcdsm_pkg::lcdsm_ctrl_t ctrl, next_ctrl;
  logic [7:0] column, next_column; // column address
  logic [4:0] page, next_page; // page address
  logic [1:0] next_operatingMode;
  logic [7:0] next_rdata;
  logic next_scanClockEnable;
  logic next_pumpEnable;
  logic next_drainEnable;
  logic next_driveEnable;
  logic inReset; // reset in progress flag
  logic softReset; // software reset command this cycle
  logic dataWrite; // accepted display data write
  logic dataRead; // accepted display data read
  logic [7:0] statusByte; // status word for the command read
  logic [lcdsm_pkg::RAM_AW-1:0] ramAddr;
  logic [7:0] ramReadData;

  // step a page address one way and wrap at the ends
  function automatic logic [4:0] stepPage(input logic [4:0] pg,
                                          input logic down);
    logic [4:0] res;
    if (down) begin
      res = (pg == 5'h00) ? lcdsm_pkg::PAGE_LAST : 5'(pg - 5'h01);
    end else begin
      res = (pg >= lcdsm_pkg::PAGE_LAST) ? 5'h00 : 5'(pg + 5'h01);
    end
    return res;
  endfunction

  // physical ram index of a page and a host column
  function automatic logic [lcdsm_pkg::RAM_AW-1:0] ramIndex(
      input logic [4:0] pg, input logic [7:0] col, input logic mirror);
    logic [7:0] phys;
    phys = mirror ? 8'(lcdsm_pkg::COL_LAST - col) : col;
    return lcdsm_pkg::RAM_AW'(pg * 8'd240 + phys);
  endfunction

  // two-flop synchronisers for the reset pin and the power-ready level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinSync1 <= 1'b1;
      pinSync2 <= 1'b1;
      pwrSync1 <= 1'b0;
      pwrSync2 <= 1'b0;
    end else if (ce) begin
      pinSync1 <= rstPinN;
      pinSync2 <= pinSync1;
      pwrSync1 <= powerGood;
      pwrSync2 <= pwrSync1;
    end
  end

  // host access qualification
  always_comb begin
    inReset = (state != Running);
    // offset 0 is a command cycle, offset 1 a data cycle
    softReset = wstrobe && !inReset && (addr == lcdsm_pkg::REG_CMD)
      && (wdata == lcdsm_pkg::SYS_RESET_CMD);
    dataWrite = wstrobe && !inReset
      && (addr == lcdsm_pkg::REG_DATA);
    dataRead = rstrobe && !inReset
      && (addr == lcdsm_pkg::REG_DATA);
    ramAddr = ramIndex(page, column, ctrl.colMirror);
  end

  // reset sequencer next state
  always_comb begin
    next_state = state;
    next_porCount = porCount;
    next_seqCount = seqCount;
    case (state)
      PorWait: begin
        // let the supply settle, then run a full reset pass
        if (porCount >= lcdsm_pkg::POR_CNT_W'(POR_CYCLES - 1)) begin
          next_state = ResetSeq;
          next_seqCount = 4'h0;
        end else begin
          next_porCount = lcdsm_pkg::POR_CNT_W'(porCount + 1'b1);
        end
      end
      ResetSeq: begin
        // a held pin keeps the pass from finishing
        if (!pinSync2) begin
          next_seqCount = 4'h0;
        end else if (seqCount >= lcdsm_pkg::RESET_SEQ_CYCLES) begin
          next_state = Running;
        end else begin
          next_seqCount = 4'(seqCount + 4'h1);
        end
      end
      Running: begin
        if (softReset || !pinSync2) begin
          next_state = ResetSeq;
          next_seqCount = 4'h0;
        end
      end
      default: begin
        next_state = ResetSeq;
        next_seqCount = 4'h0;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= PorWait;
      porCount <= '0;
      seqCount <= 4'h0;
    end else if (ce) begin
      state <= next_state;
      porCount <= next_porCount;
      seqCount <= next_seqCount;
    end
  end

  // control registers, addresses and operating mode
  always_comb begin
    next_ctrl = ctrl;
    next_column = column;
    next_page = page;
    next_operatingMode = operatingMode;
    if (inReset) begin
      // whole reset pass holds defaults and reset mode
      next_ctrl = lcdsm_pkg::CTRL_DEFAULT;
      next_column = 8'h00;
      next_page = 5'h00;
      next_operatingMode = lcdsm_pkg::OM_RESET;
    end else if (dataWrite || dataRead) begin
      // advance after each display data access, except at column 239 with wrap off
      if (column < lcdsm_pkg::COL_LAST) begin
        next_column = 8'(column + 8'h01);
      end else if (ctrl.wrapEnable) begin
        next_column = 8'h00;
        next_page = stepPage(page, ctrl.pageDir);
      end
    end else if (wstrobe) begin
      case (addr)
        lcdsm_pkg::REG_ADDR_CTRL: begin
          next_ctrl.wrapEnable = wdata[lcdsm_pkg::BIT_WRAP];
          next_ctrl.pageDir = wdata[lcdsm_pkg::BIT_PAGE_DIR];
        end
        lcdsm_pkg::REG_MAPPING: begin
          // stored data stay as they are, the host rewrites them
          next_ctrl.colMirror = wdata[lcdsm_pkg::BIT_COL_MIRROR];
          next_ctrl.rowMirror = wdata[lcdsm_pkg::BIT_ROW_MIRROR];
        end
        lcdsm_pkg::REG_DISP_CTRL: begin
          next_ctrl.driverEnable = wdata[lcdsm_pkg::BIT_DRIVER_EN];
          next_operatingMode = wdata[lcdsm_pkg::BIT_DRIVER_EN]
            ? lcdsm_pkg::OM_NORMAL : lcdsm_pkg::OM_SLEEP;
        end
        lcdsm_pkg::REG_MUX: begin
          next_ctrl.mux128 = wdata[lcdsm_pkg::BIT_MUX128];
        end
        lcdsm_pkg::REG_START_LINE: begin
          next_ctrl.startLine = wdata[6:0];
        end
        lcdsm_pkg::REG_COLUMN: begin
          next_column = wdata;
        end
        lcdsm_pkg::REG_PAGE: begin
          next_page = wdata[4:0];
        end
        lcdsm_pkg::REG_POWER: begin
          next_ctrl.extSupply = wdata[lcdsm_pkg::BIT_EXT_SUPPLY];
        end
        default: begin
          // other offsets hold nothing
        end
      endcase
    end
  end

  // control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= lcdsm_pkg::CTRL_DEFAULT;
      column <= 8'h00;
      page <= 5'h00;
      operatingMode <= lcdsm_pkg::OM_RESET;
    end else if (ce) begin
      ctrl <= next_ctrl;
      column <= next_column;
      page <= next_page;
      operatingMode <= next_operatingMode;
    end
  end

  // read data, one cycle after the read strobe
  always_comb begin
    // reset flag and busy both mirror the reset pass
    statusByte = {3'b000, comDriveEnable, operatingMode,
      inReset, inReset};
    next_rdata = 8'h00;
    if (rstrobe) begin
      if (addr == lcdsm_pkg::REG_CMD) begin
        next_rdata = statusByte;
      end else if (inReset) begin
        next_rdata = 8'h00;
      end else begin
        case (addr)
          // ram reads are pipelined: the byte from the previous read
          lcdsm_pkg::REG_DATA: next_rdata = ramReadData;
          lcdsm_pkg::REG_ADDR_CTRL: begin
            next_rdata = 8'h00;
            next_rdata[lcdsm_pkg::BIT_WRAP] = ctrl.wrapEnable;
            next_rdata[lcdsm_pkg::BIT_PAGE_DIR] = ctrl.pageDir;
          end
          lcdsm_pkg::REG_MAPPING: begin
            next_rdata = 8'h00;
            next_rdata[lcdsm_pkg::BIT_COL_MIRROR] = ctrl.colMirror;
            next_rdata[lcdsm_pkg::BIT_ROW_MIRROR] = ctrl.rowMirror;
          end
          lcdsm_pkg::REG_DISP_CTRL: begin
            next_rdata = 8'h00;
            next_rdata[lcdsm_pkg::BIT_DRIVER_EN] = ctrl.driverEnable;
          end
          lcdsm_pkg::REG_MUX: next_rdata = {7'h00, ctrl.mux128};
          lcdsm_pkg::REG_START_LINE: next_rdata = {1'b0, ctrl.startLine};
          lcdsm_pkg::REG_COLUMN: next_rdata = column;
          lcdsm_pkg::REG_PAGE: next_rdata = {3'b000, page};
          lcdsm_pkg::REG_POWER: next_rdata = {7'h00, ctrl.extSupply};
          default: next_rdata = 8'h00;
        endcase
      end
    end
  end

  // power outputs follow the operating mode
  always_comb begin
    next_scanClockEnable = (operatingMode == lcdsm_pkg::OM_NORMAL);
    next_pumpEnable = (operatingMode == lcdsm_pkg::OM_NORMAL);
    // drain never in sleep, never while extSupply is set; reset clears it
    next_drainEnable = (operatingMode == lcdsm_pkg::OM_RESET)
      && !ctrl.extSupply;
    // drivers idle until the supplies report ready
    next_driveEnable = (operatingMode == lcdsm_pkg::OM_NORMAL)
      && ctrl.driverEnable && pwrSync2;
  end

  // output registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
      scanClockEnable <= 1'b0;
      pumpEnable <= 1'b0;
      drainEnable <= 1'b0;
      comDriveEnable <= 1'b0;
      segDriveEnable <= 1'b0;
    end else if (ce) begin
      rdata <= next_rdata;
      scanClockEnable <= next_scanClockEnable;
      pumpEnable <= next_pumpEnable;
      drainEnable <= next_drainEnable;
      comDriveEnable <= next_driveEnable;
      segDriveEnable <= next_driveEnable;
    end
  end

  // display data memory
  lcdsm_ram u_ram (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .writeEn(dataWrite),
    .readEn(dataRead),
    .addr(ramAddr),
    .writeData(wdata),
    .readData(ramReadData)
  );

  // field scan runs only while the scan clock is on
  lcdsm_line_gen #(
    .LINE_CYCLES(LINE_CYCLES)
  ) u_line_gen (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .run(scanClockEnable),
    .ctrl(ctrl),
    .scan(scan)
  );
endmodule
`default_nettype wire

//--- testbench/lcdsm_top_properties.sv
// concurrent checks on the ports of the lcd scan and power block
`timescale 1ns/10ps
`default_nettype none
module lcdsm_top_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic [lcdsm_pkg::ADDR_W-1:0] addr,
  input wire logic rstrobe,
  input wire logic [7:0] rdata,
  input wire logic rstPinN,
  input wire logic powerGood,
  input wire logic [1:0] operatingMode,
  input wire logic scanClockEnable,
  input wire logic pumpEnable,
  input wire logic drainEnable,
  input wire logic comDriveEnable,
  input wire logic segDriveEnable,
  input wire lcdsm_pkg::lcdsm_scan_t scan
);
  // one clock domain, checks paused while reset is asserted
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  mode_code_a: assert property (operatingMode != 2'b01)
    else $error("operating mode holds an unused code");
  clock_gate_a: assert property (
    operatingMode != lcdsm_pkg::OM_NORMAL &&
    $past(operatingMode) != lcdsm_pkg::OM_NORMAL
    |-> !scanClockEnable && !pumpEnable)
    else $error("scan clock or pump running outside normal mode");
  drain_mode_a: assert property (drainEnable |->
    operatingMode == lcdsm_pkg::OM_RESET ||
    $past(operatingMode) == lcdsm_pkg::OM_RESET)
    else $error("drain active outside reset mode");
  drive_ready_a: assert property (comDriveEnable |->
    $past(powerGood, 3) && $past(operatingMode) == lcdsm_pkg::OM_NORMAL)
    else $error("drivers active before power ready or out of normal");
  seg_match_a: assert property (segDriveEnable == comDriveEnable)
    else $error("segment and common drivers disagree");
  com_order_a: assert property ($changed(scan.comIndex) |->
    scan.comIndex == $past(scan.comIndex) + 7'h01 ||
    (scan.comIndex == 7'h00 && scan.firstLine))
    else $error("common scan left its fixed order");
  line_step_a: assert property (
    $changed(scan.comIndex) && !scan.firstLine |->
    scan.ramLine == $past(scan.ramLine) + 7'h01 ||
    scan.ramLine == $past(scan.ramLine) - 7'h01)
    else $error("ram line did not step by one");
  first_com_a: assert property (scan.firstLine |-> scan.comIndex == 7'h00)
    else $error("first line flag away from first common");
  read_idle_a: assert property (!$past(rstrobe) |-> rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  reset_status_a: assert property (
    $past(rstrobe) && $past(addr) == lcdsm_pkg::REG_CMD &&
    $past(rstPinN, 6) == 1'b0 && $past(rstPinN, 2) == 1'b0
    |-> rdata[1:0] == 2'b11)
    else $error("status bits low during pin reset");
  pin_mode_a: assert property (
    $past(rstPinN, 5) == 1'b0 && $past(rstPinN) == 1'b0
    |-> operatingMode == lcdsm_pkg::OM_RESET)
    else $error("reset pin did not force reset mode");

  // main scenarios reached
  drive_on_c: cover property (comDriveEnable);
  field_wrap_c: cover property (scan.firstLine && scanClockEnable);
  sleep_c: cover property (operatingMode == lcdsm_pkg::OM_SLEEP);
endmodule
`default_nettype wire

//--- testbench/lcdsm_host_model.sv
// host microcontroller model driving the register port
`timescale 1ns/10ps
`default_nettype none
module lcdsm_host_model (
  input wire logic clk,
  output logic [lcdsm_pkg::ADDR_W-1:0] addr,
  output logic [7:0] wdata,
  output logic wstrobe,
  output logic rstrobe,
  input wire logic [7:0] rdata
);
  // bus idles with both strobes low
  initial begin
    addr = 4'h0;
    wdata = 8'h00;
    wstrobe = 1'b0;
    rstrobe = 1'b0;
  end
  // one write cycle; offset picks command or display data
  task automatic busWrite(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wstrobe <= 1'b1;
    @(posedge clk);
    wstrobe <= 1'b0;
    wdata <= ~d; // released data must not keep its last value
  endtask
  // one read cycle; the answer is taken mid-cycle after the strobe
  task automatic busRead(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rstrobe <= 1'b1;
    @(posedge clk);
    rstrobe <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
endmodule
`default_nettype wire

//--- testbench/lcdsm_top_bench.sv
// self-checking bench for the lcd scan and power block
`timescale 1ns/10ps
`default_nettype none
module lcdsm_top_bench;
  logic clk = 1'b0; // 40 MHz
  logic rst = 1'b1;
  logic ce = 1'b1; // never frozen here
  logic rstPinN = 1'b1;
  logic powerGood = 1'b0; // analog ready level
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wstrobe;
  logic rstrobe;
  logic [1:0] operatingMode;
  logic scanClockEnable, pumpEnable, drainEnable;
  logic comDriveEnable, segDriveEnable;
  lcdsm_pkg::lcdsm_scan_t scan;
  int num_errors = 0;
  int check_count = 0;

  always #12.5 clk = ~clk;

  lcdsm_top #(.POR_CYCLES(20), .LINE_CYCLES(4)) u_lcdsm_top (.clk(clk),
    .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wstrobe(wstrobe),
    .rstrobe(rstrobe), .rdata(rdata), .rstPinN(rstPinN),
    .powerGood(powerGood), .operatingMode(operatingMode),
    .scanClockEnable(scanClockEnable), .pumpEnable(pumpEnable),
    .drainEnable(drainEnable), .comDriveEnable(comDriveEnable),
    .segDriveEnable(segDriveEnable), .scan(scan));
  lcdsm_host_model u_lcdsm_host_model (.clk(clk), .addr(addr),
    .wdata(wdata), .wstrobe(wstrobe), .rstrobe(rstrobe), .rdata(rdata));

  // compare one byte and count it
  task chk(input string name, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask
  // short bus helpers
  task wr(input logic [3:0] a, input logic [7:0] d);
    u_lcdsm_host_model.busWrite(a, d);
  endtask
  task rdChk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_lcdsm_host_model.busRead(a, d);
    chk("readData", e, d);
  endtask
  // mode and power outputs against expected levels
  task outChk(input logic [1:0] m, input logic run, input logic dr,
    input logic drv);
    chk("mode", {6'h00, m}, {6'h00, operatingMode});
    chk("scanClock", {7'h00, run}, {7'h00, scanClockEnable});
    chk("pump", {7'h00, run}, {7'h00, pumpEnable});
    chk("drain", {7'h00, dr}, {7'h00, drainEnable});
    chk("comDrive", {7'h00, drv}, {7'h00, comDriveEnable});
    chk("segDrive", {7'h00, drv}, {7'h00, segDriveEnable});
  endtask
  // poll status until the reset flag clears, bounded
  task waitReady;
    logic [7:0] d;
    int n;
    d = 8'h01;
    n = 0;
    while (d[0] !== 1'b0 && n < 200) begin
      u_lcdsm_host_model.busRead(lcdsm_pkg::REG_CMD, d);
      n++;
    end
    chk("readyFlag", 8'h00, {7'h00, d[0]});
  endtask
  // one field boundary: last common, first and second ram line
  task scanChk(input logic [6:0] f, input logic dn, input logic [6:0] lc);
    logic [6:0] prev;
    int n;
    n = 0;
    while (scan.comIndex !== 7'h01 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    prev = 7'h00;
    while (scan.comIndex !== 7'h00 && n < 4000) begin
      prev = scan.comIndex;
      @(posedge clk);
      n++;
    end
    chk("lastCom", {1'b0, lc}, {1'b0, prev});
    chk("firstRamLine", {1'b0, f}, {1'b0, scan.ramLine});
    while (scan.comIndex !== 7'h01 && n < 4100) begin
      @(posedge clk);
      n++;
    end
    chk("nextRamLine", {1'b0, dn ? f - 7'h01 : f + 7'h01},
      {1'b0, scan.ramLine});
  endtask
  // print counts and verdict, then stop
  task summarize;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    summarize;
  end

  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rdChk(lcdsm_pkg::REG_CMD, 8'h03);
    wr(lcdsm_pkg::REG_MUX, 8'h00);
    waitReady;
    rdChk(lcdsm_pkg::REG_MUX, 8'h01);
    outChk(lcdsm_pkg::OM_RESET, 1'b0, 1'b1, 1'b0);
    // normal mode, drivers held until power ready
    wr(lcdsm_pkg::REG_START_LINE, 8'h05);
    wr(lcdsm_pkg::REG_MUX, 8'h00);
    wr(lcdsm_pkg::REG_DISP_CTRL, 8'h04);
    repeat (4) @(posedge clk);
    outChk(lcdsm_pkg::OM_NORMAL, 1'b1, 1'b0, 1'b0);
    powerGood <= 1'b1;
    repeat (5) @(posedge clk);
    outChk(lcdsm_pkg::OM_NORMAL, 1'b1, 1'b0, 1'b1);
    scanChk(7'h05, 1'b0, 7'h5F);
    wr(lcdsm_pkg::REG_MAPPING, 8'h08);
    scanChk(7'h64, 1'b1, 7'h5F);
    wr(lcdsm_pkg::REG_MUX, 8'h01);
    scanChk(7'h04, 1'b1, 7'h7F);
    wr(lcdsm_pkg::REG_DISP_CTRL, 8'h00);
    repeat (4) @(posedge clk);
    outChk(lcdsm_pkg::OM_SLEEP, 1'b0, 1'b0, 1'b0);
    // wrap on, page stepping up across the last page
    wr(lcdsm_pkg::REG_ADDR_CTRL, 8'h01);
    wr(lcdsm_pkg::REG_PAGE, 8'h13);
    wr(lcdsm_pkg::REG_COLUMN, 8'hEE);
    wr(lcdsm_pkg::REG_DATA, 8'hA1);
    wr(lcdsm_pkg::REG_DATA, 8'hA2);
    wr(lcdsm_pkg::REG_DATA, 8'hA3);
    // page stepping down across page zero
    wr(lcdsm_pkg::REG_ADDR_CTRL, 8'h05);
    wr(lcdsm_pkg::REG_PAGE, 8'h00);
    wr(lcdsm_pkg::REG_COLUMN, 8'hEF);
    wr(lcdsm_pkg::REG_DATA, 8'hB1);
    wr(lcdsm_pkg::REG_DATA, 8'hB2);
    // wrap off, column sticks at the page end
    wr(lcdsm_pkg::REG_ADDR_CTRL, 8'h00);
    wr(lcdsm_pkg::REG_PAGE, 8'h01);
    wr(lcdsm_pkg::REG_COLUMN, 8'hEF);
    wr(lcdsm_pkg::REG_DATA, 8'hC1);
    wr(lcdsm_pkg::REG_DATA, 8'hC2);
    // mirrored column zero lands on column 239
    wr(lcdsm_pkg::REG_MAPPING, 8'h04);
    wr(lcdsm_pkg::REG_PAGE, 8'h02);
    wr(lcdsm_pkg::REG_COLUMN, 8'h00);
    wr(lcdsm_pkg::REG_DATA, 8'hD1);
    wr(lcdsm_pkg::REG_MAPPING, 8'h00);
    // read back: every data read returns the previous fetch
    wr(lcdsm_pkg::REG_PAGE, 8'h13);
    wr(lcdsm_pkg::REG_COLUMN, 8'hEE);
    rdChk(lcdsm_pkg::REG_DATA, 8'h00);
    rdChk(lcdsm_pkg::REG_DATA, 8'hA1);
    rdChk(lcdsm_pkg::REG_DATA, 8'hA2);
    wr(lcdsm_pkg::REG_PAGE, 8'h00);
    wr(lcdsm_pkg::REG_COLUMN, 8'h00);
    rdChk(lcdsm_pkg::REG_DATA, 8'hA2);
    wr(lcdsm_pkg::REG_PAGE, 8'h13);
    wr(lcdsm_pkg::REG_COLUMN, 8'h00);
    rdChk(lcdsm_pkg::REG_DATA, 8'hA3);
    wr(lcdsm_pkg::REG_PAGE, 8'h01);
    wr(lcdsm_pkg::REG_COLUMN, 8'hEF);
    rdChk(lcdsm_pkg::REG_DATA, 8'hB2);
    rdChk(lcdsm_pkg::REG_DATA, 8'hC2);
    wr(lcdsm_pkg::REG_PAGE, 8'h02);
    wr(lcdsm_pkg::REG_COLUMN, 8'hEF);
    rdChk(lcdsm_pkg::REG_DATA, 8'hC2);
    rdChk(lcdsm_pkg::REG_DATA, 8'hD1);
    rdChk(lcdsm_pkg::REG_DATA, 8'hD1);
    rdChk(4'hF, 8'h00);
    // software reset restores control register defaults
    wr(lcdsm_pkg::REG_MAPPING, 8'h0C);
    wr(lcdsm_pkg::REG_CMD, lcdsm_pkg::SYS_RESET_CMD);
    rdChk(lcdsm_pkg::REG_CMD, 8'h03);
    wr(lcdsm_pkg::REG_DISP_CTRL, 8'h04);
    outChk(lcdsm_pkg::OM_RESET, 1'b0, 1'b1, 1'b0);
    waitReady;
    wr(lcdsm_pkg::REG_POWER, 8'h01);
    rdChk(lcdsm_pkg::REG_MAPPING, 8'h00);
    rdChk(lcdsm_pkg::REG_START_LINE, 8'h00);
    rdChk(lcdsm_pkg::REG_MUX, 8'h01);
    outChk(lcdsm_pkg::OM_RESET, 1'b0, 1'b0, 1'b0);
    // reset pin from normal mode
    wr(lcdsm_pkg::REG_DISP_CTRL, 8'h04);
    rstPinN <= 1'b0;
    repeat (8) @(posedge clk);
    rdChk(lcdsm_pkg::REG_CMD, 8'h03);
    outChk(lcdsm_pkg::OM_RESET, 1'b0, 1'b1, 1'b0);
    rstPinN <= 1'b1;
    waitReady;
    summarize;
  end
endmodule
`default_nettype wire

bind lcdsm_top lcdsm_top_properties u_lcdsm_top_properties (.clk(clk),
  .rst(rst), .addr(addr), .rstrobe(rstrobe), .rdata(rdata),
  .rstPinN(rstPinN), .powerGood(powerGood),
  .operatingMode(operatingMode), .scanClockEnable(scanClockEnable),
  .pumpEnable(pumpEnable), .drainEnable(drainEnable),
  .comDriveEnable(comDriveEnable), .segDriveEnable(segDriveEnable),
  .scan(scan));
